//--- logic/ddc_cfg_pkg.sv
// shared constants, types and decode functions for the ddc configuration block
package ddc_cfg_pkg;
  localparam int          SAMPLE_W       = 16;
  localparam int          FIFO_DEPTH     = 4;
  localparam int          GAIN_BIT       = 6;
  localparam int          C2R_BIT        = 3;
  localparam logic [9:0]  IDX_PATH       = 10'h370;
  localparam logic [9:0]  IDX_EXT_DECIM  = 10'h371;
  localparam logic [9:0]  IDX_NCO_CTRL   = 10'h374;
  localparam logic [9:0]  IDX_STATUS     = 10'h37f;
  localparam logic [11:0] ADDR_PATH      = {IDX_PATH, 2'b00};
  localparam logic [11:0] ADDR_EXT_DECIM = {IDX_EXT_DECIM, 2'b00};
  localparam logic [11:0] ADDR_NCO_CTRL  = {IDX_NCO_CTRL, 2'b00};
  localparam logic [11:0] ADDR_STATUS    = {IDX_STATUS, 2'b00};
  localparam logic [7:0]  PATH_RESET     = 8'h00;
  localparam logic [7:0]  EXT_RESET      = 8'h00;
  localparam logic [7:0]  NCO_RESET      = 8'h00;
  localparam logic [7:0]  PATH_WMASK     = 8'h4f;
  localparam logic [7:0]  EXT_WMASK      = 8'hf0;
  localparam logic [7:0]  NCO_WMASK      = 8'hff;
  localparam logic [3:0]  COUNT_RESET    = 4'h0;
  localparam logic [2:0]  DSEL_EXT       = 3'h7;
  localparam logic [3:0]  MODE_REG       = 4'h0;
  localparam logic [3:0]  MODE_PINS      = 4'h1;
  localparam logic [3:0]  MODE_EDGE_ONE  = 4'h8;
  localparam logic [3:0]  MODE_EDGE_TWO  = 4'ha;

  typedef enum logic [1:0] {
    APB_IDLE   = 2'h1,
    APB_ANSWER = 2'h2
  } apb_phase_type;

  typedef struct packed {
    logic signed [SAMPLE_W-1:0] i;
    logic signed [SAMPLE_W-1:0] q;
  } sample_type;

  typedef struct packed {
    logic fifth_band_stage;
    logic third_band_stage;
    logic halfband_stage_four;
    logic halfband_stage_three;
    logic halfband_stage_two;
    logic halfband_stage_one;
  } stage_mask_type;

  typedef struct packed {
    apb_phase_type  phase;
    logic [7:0]     path;
    logic [7:0]     ext;
    logic [7:0]     nco;
    logic [7:0]     rdata;
    logic           err;
    logic [1:0]     mix_phase;
    logic [5:0]     decim_cnt;
    logic [5:0]     ratio;
    stage_mask_type stages;
    logic [3:0]     active_ch;
  } core_state_type;

  localparam core_state_type CORE_RESET = '{phase: APB_IDLE, path: PATH_RESET,
    ext: EXT_RESET, nco: NCO_RESET, default: '0};

  // ratio with real output; unlisted extended codes act as code 0
  function automatic logic [5:0] real_ratio(input logic [2:0] sel, input logic [3:0] ext);
    case (sel)
      3'h0: real_ratio = 6'h02;
      3'h1: real_ratio = 6'h04;
      3'h2: real_ratio = 6'h08;
      3'h3: real_ratio = 6'h01;
      3'h4: real_ratio = 6'h03;
      3'h5: real_ratio = 6'h06;
      3'h6: real_ratio = 6'h0c;
      default: begin
        case (ext)
          4'h2: real_ratio = 6'h05;
          4'h3: real_ratio = 6'h0a;
          4'h4: real_ratio = 6'h14;
          default: real_ratio = 6'h18;
        endcase
      end
    endcase
  endfunction

  function automatic logic [5:0] decim_ratio(input logic [2:0] sel, input logic [3:0] ext,
                                             input logic c2r);
    logic [5:0] base;
    base = real_ratio(sel, ext);
    decim_ratio = c2r ? base : {base[4:0], 1'b0};
  endfunction

  function automatic stage_mask_type stage_mask(input logic [2:0] sel, input logic [3:0] ext);
    case (sel)
      3'h0: stage_mask = 6'b000011;
      3'h1: stage_mask = 6'b000111;
      3'h2: stage_mask = 6'b001111;
      3'h3: stage_mask = 6'b000001;
      3'h4: stage_mask = 6'b010001;
      3'h5: stage_mask = 6'b010011;
      3'h6: stage_mask = 6'b010111;
      default: begin
        case (ext)
          4'h2: stage_mask = 6'b100001;
          4'h3: stage_mask = 6'b100011;
          4'h4: stage_mask = 6'b100111;
          default: stage_mask = 6'b011111;
        endcase
      end
    endcase
  endfunction

  function automatic logic [SAMPLE_W-1:0] sat_double(input logic [SAMPLE_W-1:0] x);
    if (x[SAMPLE_W-1] != x[SAMPLE_W-2]) begin
      sat_double = x[SAMPLE_W-1] ? {1'b1, {(SAMPLE_W-1){1'b0}}} : {1'b0, {(SAMPLE_W-1){1'b1}}};
    end else begin
      sat_double = {x[SAMPLE_W-2:0], 1'b0};
    end
  endfunction

  function automatic logic [SAMPLE_W-1:0] neg_sat(input logic [SAMPLE_W-1:0] x);
    if (x == {1'b1, {(SAMPLE_W-1){1'b0}}}) begin
      neg_sat = {1'b0, {(SAMPLE_W-1){1'b1}}};
    end else begin
      neg_sat = -x;
    end
  endfunction
endpackage

//--- logic/sample_fifo.sv
// flop based fifo with valid and ready on both sides
`timescale 1ns/1ps
module sample_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
)(
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int            PW       = $clog2(DEPTH);
  localparam logic [PW:0]   CNT_FULL = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr;
    logic [PW-1:0]               rd;
    logic [PW:0]                 count;
  } fifo_state_type;

  fifo_state_type s_r;
  fifo_state_type s_nxt;
  logic           do_push;
  logic           do_pop;

  assign in_ready  = (s_r.count != CNT_FULL);
  assign out_valid = (s_r.count != '0);
  assign out_data  = s_r.mem[s_r.rd];
  assign do_push   = in_valid && in_ready;
  assign do_pop    = out_valid && out_ready;

  always_comb begin
    s_nxt = s_r;
    if (do_push) begin
      s_nxt.mem[s_r.wr] = in_data;
      s_nxt.wr = (s_r.wr == PTR_LAST) ? '0 : s_r.wr + 1'b1;
    end
    if (do_pop) begin
      s_nxt.rd = (s_r.rd == PTR_LAST) ? '0 : s_r.rd + 1'b1;
    end
    if (do_push && !do_pop) begin
      s_nxt.count = s_r.count + 1'b1;
    end else if (do_pop && !do_push) begin
      s_nxt.count = s_r.count - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  chk_fifo_level: assert property (@(posedge clk) disable iff (reset)
    do_push && !do_pop |=> s_r.count == $past(s_r.count) + 1'b1)
    else $error("fifo level not raised by push");
endmodule

//--- logic/edge_channel_counter.sv
// pin edge counter that picks the nco channel in the edge modes
`timescale 1ns/1ps
module edge_channel_counter
  import ddc_cfg_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       first_select_pin,
  input  wire logic       second_select_pin,
  input  wire logic       count_en,
  input  wire logic       use_second,
  input  wire logic [3:0] wrap_limit,
  output logic [3:0]      count
);
  typedef struct packed {
    logic [3:0] cnt;
    logic       first_d;
    logic       second_d;
  } edge_state_type;

  edge_state_type s_r;
  edge_state_type s_nxt;
  logic           rise;

  assign count = s_r.cnt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.first_d = first_select_pin;
    s_nxt.second_d = second_select_pin;
    rise = use_second ? (second_select_pin && !s_r.second_d)
                      : (first_select_pin && !s_r.first_d);
    if (count_en && rise) begin
      if (s_r.cnt >= wrap_limit) begin
        s_nxt.cnt = COUNT_RESET;
      end else begin
        s_nxt.cnt = s_r.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_r <= '{cnt: COUNT_RESET, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  chk_counter_wrap: assert property (@(posedge clk) disable iff (reset)
    count_en && rise && s_r.cnt >= wrap_limit |=> s_r.cnt == 4'h0)
    else $error("edge counter missed its wrap");

  chk_counter_step: assert property (@(posedge clk) disable iff (reset)
    count_en && rise && s_r.cnt < wrap_limit |=> s_r.cnt == $past(s_r.cnt) + 4'h1)
    else $error("edge counter did not advance");
endmodule

//--- logic/ddc_decimation_nco_select.sv
// ddc channel gain, real conversion, decimation select and nco channel select
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
module ddc_decimation_nco_select
  import ddc_cfg_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
)(
  input  wire logic                CLK,
  input  wire logic                RESET,
  input  wire logic                PSEL,
  input  wire logic                PENABLE,
  input  wire logic                PWRITE,
  input  wire logic [11:0]         PADDR,
  input  wire logic [31:0]         PWDATA,
  input  wire logic [3:0]          PSTRB,
  output logic                     PREADY,
  output logic [31:0]              PRDATA,
  output logic                     PSLVERR,
  input  wire logic                S_VALID,
  output logic                     S_READY,
  input  wire logic [SAMPLE_W-1:0] S_I,
  input  wire logic [SAMPLE_W-1:0] S_Q,
  output logic                     M_VALID,
  input  wire logic                M_READY,
  output logic [SAMPLE_W-1:0]      M_I,
  output logic [SAMPLE_W-1:0]      M_Q,
  input  wire logic                FIRST_SELECT_PIN,
  input  wire logic                SECOND_SELECT_PIN,
  output logic [3:0]               NCO_CHANNEL,
  output logic [3:0]               MAP_CHANNEL,
  output logic [5:0]               DECIM_RATIO,
  output logic [5:0]               STAGE_ENABLES,
  output logic                     REAL_OUTPUT,
  output logic                     GAIN_ON
);
  core_state_type s_r;
  core_state_type s_nxt;
  sample_type     in_smp;
  sample_type     mix_smp;
  sample_type     push_smp;
  sample_type     pop_smp;
  logic           gain_on;
  logic           c2r_on;
  logic           in_fire;
  logic           push;
  logic           fifo_ready;
  logic           fifo_valid;
  logic [2:0]     dsel;
  logic [3:0]     ext_code;
  logic [3:0]     mode;
  logic [3:0]     map_ch;
  logic [3:0]     edge_count;
  logic           edge_en;
  logic           mapped;
  logic [7:0]     rd_val;
  logic [31:0]    pop_bits;

  assign gain_on  = s_r.path[GAIN_BIT];
  assign c2r_on   = s_r.path[C2R_BIT];
  assign dsel     = s_r.path[2:0];
  assign ext_code = s_r.ext[7:4];
  assign mode     = s_r.nco[7:4];
  assign map_ch   = s_r.nco[3:0];
  assign in_smp   = '{i: S_I, q: S_Q};
  assign in_fire  = S_VALID && S_READY;
  assign push     = in_fire && (s_r.decim_cnt == 6'h00);
  assign edge_en  = (mode == MODE_EDGE_ONE) || (mode == MODE_EDGE_TWO);

  // sample path: fs/4 mix for real output, then optional gain
  always_comb begin
    mix_smp = in_smp;
    if (c2r_on) begin
      case (s_r.mix_phase)
        2'h0: begin
          mix_smp.i = in_smp.i;
        end
        2'h1: begin
          mix_smp.i = neg_sat(in_smp.q);
        end
        2'h2: begin
          mix_smp.i = neg_sat(in_smp.i);
        end
        default: begin
          mix_smp.i = in_smp.q;
        end
      endcase
      mix_smp.q = '0;
    end
    push_smp = mix_smp;
    if (gain_on) begin
      push_smp.i = sat_double(mix_smp.i);
      push_smp.q = sat_double(mix_smp.q);
    end
  end

  // register read decode
  always_comb begin
    mapped = 1'b1;
    rd_val = 8'h00;
    if (PADDR == ADDR_PATH) begin
      rd_val = s_r.path;
    end else if (PADDR == ADDR_EXT_DECIM) begin
      rd_val = s_r.ext;
    end else if (PADDR == ADDR_NCO_CTRL) begin
      rd_val = s_r.nco;
    end else if (PADDR == ADDR_STATUS) begin
      rd_val = {edge_count, s_r.active_ch};
    end else begin
      mapped = 1'b0;
    end
  end

  always_comb begin
    s_nxt = s_r;
    // apb slave with one wait state
    case (s_r.phase)
      APB_IDLE: begin
        if (PSEL && PENABLE) begin
          s_nxt.phase = APB_ANSWER;
          s_nxt.rdata = rd_val;
          s_nxt.err = !mapped;
        end
      end
      APB_ANSWER: begin
        s_nxt.phase = APB_IDLE;
        if (PWRITE && PSTRB[0] && !s_r.err) begin
          if (PADDR == ADDR_PATH) begin
            s_nxt.path = PWDATA[7:0] & PATH_WMASK;
          end else if (PADDR == ADDR_EXT_DECIM) begin
            s_nxt.ext = PWDATA[7:0] & EXT_WMASK;
          end else if (PADDR == ADDR_NCO_CTRL) begin
            s_nxt.nco = PWDATA[7:0] & NCO_WMASK;
          end
        end
      end
      default: begin
        s_nxt.phase = APB_IDLE;
      end
    endcase
    // decimation and mixing phase advance on accepted samples
    if (in_fire) begin
      if (c2r_on) begin
        s_nxt.mix_phase = s_r.mix_phase + 2'h1;
      end
      if (s_r.decim_cnt + 6'h01 >= s_r.ratio) begin
        s_nxt.decim_cnt = 6'h00;
      end else begin
        s_nxt.decim_cnt = s_r.decim_cnt + 6'h01;
      end
    end
    s_nxt.ratio = decim_ratio(dsel, ext_code, c2r_on);
    s_nxt.stages = stage_mask(dsel, ext_code);
    // active nco channel
    case (mode)
      MODE_PINS: begin
        s_nxt.active_ch = {2'b00, SECOND_SELECT_PIN, FIRST_SELECT_PIN};
      end
      MODE_EDGE_ONE, MODE_EDGE_TWO: begin
        s_nxt.active_ch = edge_count;
      end
      default: begin
        s_nxt.active_ch = map_ch;
      end
    endcase
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      s_r <= CORE_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  edge_channel_counter u_edge (
    .clk               (CLK),
    .reset             (RESET),
    .first_select_pin  (FIRST_SELECT_PIN),
    .second_select_pin (SECOND_SELECT_PIN),
    .count_en          (edge_en),
    .use_second        (mode == MODE_EDGE_TWO),
    .wrap_limit        (map_ch),
    .count             (edge_count)
  );

  sample_fifo #(
    .WIDTH (2 * SAMPLE_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (CLK),
    .reset     (RESET),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   (push_smp),
    .out_valid (fifo_valid),
    .out_ready (M_READY),
    .out_data  (pop_bits)
  );

  assign pop_smp       = pop_bits;
  assign S_READY       = fifo_ready;
  assign M_VALID       = fifo_valid;
  assign M_I           = pop_smp.i;
  assign M_Q           = pop_smp.q;
  assign PREADY        = (s_r.phase == APB_ANSWER);
  assign PRDATA        = {24'h000000, s_r.rdata};
  assign PSLVERR       = PREADY && s_r.err;
  assign NCO_CHANNEL   = s_r.active_ch;
  assign MAP_CHANNEL   = map_ch;
  assign DECIM_RATIO   = s_r.ratio;
  assign STAGE_ENABLES = s_r.stages;
  assign REAL_OUTPUT   = c2r_on;
  assign GAIN_ON       = gain_on;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);

  chk_gain_double: assert property (
    push && gain_on && !c2r_on |-> push_smp.i == sat_double(S_I))
    else $error("gain option did not double the sample");

  chk_gain_plain: assert property (
    push && !gain_on && !c2r_on |-> push_smp.i == S_I && push_smp.q == S_Q)
    else $error("sample altered with gain option clear");

  chk_real_output: assert property (
    push && c2r_on |-> push_smp.q == '0)
    else $error("real output carries a q sample");

  chk_quarter_mix: assert property (
    push && c2r_on && !gain_on && s_r.mix_phase == 2'h2 |-> push_smp.i == neg_sat(S_I))
    else $error("fs/4 mixing sign wrong");

  chk_mix_step: assert property (
    in_fire && c2r_on |=> s_r.mix_phase == $past(s_r.mix_phase) + 2'h1)
    else $error("mixing phase did not advance");

  chk_ratio_half: assert property (
    dsel == 3'h3 && !c2r_on |=> DECIM_RATIO == 6'h02 && STAGE_ENABLES == 6'b000001)
    else $error("single halfband ratio wrong");

  chk_ratio_four: assert property (
    dsel == 3'h2 && c2r_on |=> DECIM_RATIO == 6'h08)
    else $error("four halfband ratio wrong");

  chk_ratio_third: assert property (
    dsel == 3'h6 && !c2r_on |=> DECIM_RATIO == 6'h18 && STAGE_ENABLES == 6'b010111)
    else $error("third-band chain ratio wrong");

  chk_ext_gated: assert property (
    dsel != DSEL_EXT |=> !STAGE_ENABLES[5])
    else $error("extended field acted without code 111");

  chk_ratio_full: assert property (
    dsel == DSEL_EXT && ext_code == 4'h0 && !c2r_on |=> DECIM_RATIO == 6'h30)
    else $error("full chain ratio not 48");

  chk_ratio_fifth: assert property (
    dsel == DSEL_EXT && ext_code == 4'h3 && c2r_on |=> DECIM_RATIO == 6'h0a)
    else $error("fifth-band chain ratio wrong");

  chk_reg_channel: assert property (
    mode == MODE_REG |=> NCO_CHANNEL == $past(map_ch))
    else $error("register channel not applied");

  chk_pin_channel: assert property (
    mode == MODE_PINS |=> NCO_CHANNEL[3:2] == 2'b00
      && NCO_CHANNEL[1] == $past(SECOND_SELECT_PIN)
      && NCO_CHANNEL[0] == $past(FIRST_SELECT_PIN))
    else $error("pin channel not applied");

  chk_edge_channel: assert property (
    mode == MODE_EDGE_ONE |=> NCO_CHANNEL == $past(edge_count))
    else $error("edge counter channel not applied");

  chk_edge_limit: assert property (
    edge_en && edge_count <= map_ch && $stable(map_ch) |=> edge_count <= $past(map_ch))
    else $error("edge counter passed its limit");

  chk_map_write: assert property (
    PREADY && PWRITE && PSTRB[0] && PADDR == ADDR_NCO_CTRL |=> MAP_CHANNEL == $past(PWDATA[3:0]))
    else $error("channel field write lost");

  chk_reserved_zero: assert property (
    PREADY && PADDR == ADDR_EXT_DECIM |-> PRDATA[3:0] == 4'h0 && PRDATA[31:8] == '0)
    else $error("reserved bits read nonzero");

  chk_apb_wait: assert property (
    PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
    else $error("apb answer not after one wait cycle");

  chk_decim_pace: assert property (
    push && s_r.ratio == 6'h02 |=> s_r.decim_cnt == 6'h01 && !push)
    else $error("decimation passed two samples in a row");

  chk_mix_phase_zero: assert property (
    push && c2r_on && !gain_on && s_r.mix_phase == 2'h0 |-> push_smp.i == S_I)
    else $error("fs/4 mixing altered phase zero sample");

  chk_mix_phase_one: assert property (
    push && c2r_on && !gain_on && s_r.mix_phase == 2'h1 |-> push_smp.i == neg_sat(S_Q))
    else $error("fs/4 mixing phase one wrong");

  chk_ratio_third_real: assert property (
    dsel == 3'h4 && c2r_on |=> DECIM_RATIO == 6'h03 && STAGE_ENABLES == 6'b010001)
    else $error("real third-band ratio wrong");

  chk_edge_two_channel: assert property (
    mode == MODE_EDGE_TWO |=> NCO_CHANNEL == $past(edge_count))
    else $error("second pin counter channel not applied");

  chk_status_read: assert property (
    PREADY && !PWRITE && PADDR == ADDR_STATUS
      |-> PRDATA[7:0] == $past({edge_count, s_r.active_ch}))
    else $error("status read wrong");

  chk_unmapped_err: assert property (
    PSEL && PENABLE && !PREADY && PADDR == 12'h000 |=> PSLVERR)
    else $error("unmapped access without error");

  chk_path_mask: assert property (
    PREADY && PWRITE && PSTRB[0] && PADDR == ADDR_PATH
      |=> s_r.path == ($past(PWDATA[7:0]) & PATH_WMASK))
    else $error("path write not masked");

  chk_strobe_ignore: assert property (
    PREADY && PWRITE && !PSTRB[0]
      |=> $stable(s_r.path) && $stable(s_r.ext) && $stable(s_r.nco))
    else $error("write without strobe changed a register");

  chk_unmapped_write: assert property (
    PREADY && PSLVERR
      |=> $stable(s_r.path) && $stable(s_r.ext) && $stable(s_r.nco))
    else $error("unmapped write changed a register");
endmodule

//--- tb/tb_ddc_decimation_nco_select.sv
// self-checking bench for the ddc configuration block
`timescale 1ns/1ps
module tb_ddc_decimation_nco_select
  import ddc_cfg_pkg::*;
;
  logic                CLK, RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic                S_VALID, S_READY, M_VALID, M_READY, REAL_OUTPUT, GAIN_ON;
  logic                FIRST_SELECT_PIN, SECOND_SELECT_PIN;
  logic [11:0]         PADDR;
  logic [31:0]         PWDATA, PRDATA;
  logic [3:0]          PSTRB, NCO_CHANNEL, MAP_CHANNEL;
  logic [SAMPLE_W-1:0] S_I, S_Q, M_I, M_Q;
  logic [5:0]          DECIM_RATIO, STAGE_ENABLES;
  logic [7:0]          rd;
  logic                e;
  int                  err_count, checked;
  logic [5:0]          rr [11] = '{6'h02, 6'h04, 6'h08, 6'h01, 6'h03, 6'h06, 6'h0c,
                                   6'h18, 6'h05, 6'h0a, 6'h14};
  logic [5:0]          sm [11] = '{6'h03, 6'h07, 6'h0f, 6'h01, 6'h11, 6'h13, 6'h17,
                                   6'h1f, 6'h21, 6'h23, 6'h27};
  logic [3:0]          ec [11] = '{4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'h2,
                                   4'h0, 4'h2, 4'h3, 4'h4};

  ddc_decimation_nco_select #(.DEPTH(FIFO_DEPTH)) u_dut (
    .CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PREADY(PREADY), .PRDATA(PRDATA),
    .PSLVERR(PSLVERR), .S_VALID(S_VALID), .S_READY(S_READY), .S_I(S_I), .S_Q(S_Q),
    .M_VALID(M_VALID), .M_READY(M_READY), .M_I(M_I), .M_Q(M_Q),
    .FIRST_SELECT_PIN(FIRST_SELECT_PIN), .SECOND_SELECT_PIN(SECOND_SELECT_PIN),
    .NCO_CHANNEL(NCO_CHANNEL), .MAP_CHANNEL(MAP_CHANNEL), .DECIM_RATIO(DECIM_RATIO),
    .STAGE_ENABLES(STAGE_ENABLES), .REAL_OUTPUT(REAL_OUTPUT), .GAIN_ON(GAIN_ON)
  );

  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic do_reset();
    RESET <= 1'b1;
    repeat (20) @(posedge CLK);
    RESET <= 1'b0;
    @(posedge CLK);
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= {24'h000000, d};
    PSTRB <= s;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    check("pready", PREADY, 1'b1);
    rd = PRDATA[7:0];
    e = PSLVERR;
    check("prdata upper", PRDATA[31:8], 32'h0);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 4'h1);
    repeat (4) @(posedge CLK);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00, 4'h0);
    check("read data", rd, exp);
    check("pslverr", e, 1'b0);
  endtask

  task automatic push(input logic [15:0] i, input logic [15:0] q);
    int n;
    n = 0;
    @(posedge CLK);
    S_VALID <= 1'b1;
    S_I <= i;
    S_Q <= q;
    do begin
      @(posedge CLK);
      n++;
    end while (S_READY !== 1'b1 && n < 50);
    check("s_ready", S_READY, 1'b1);
    S_VALID <= 1'b0;
  endtask

  task automatic pop(input logic [15:0] ei, input logic [15:0] eq);
    int n;
    n = 0;
    @(posedge CLK);
    M_READY <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
    end while (M_VALID !== 1'b1 && n < 50);
    check("m_valid", M_VALID, 1'b1);
    check("m_i", M_I, ei);
    check("m_q", M_Q, eq);
    M_READY <= 1'b0;
  endtask

  task automatic pulse(input logic second);
    @(posedge CLK);
    if (second) begin
      SECOND_SELECT_PIN <= 1'b1;
    end else begin
      FIRST_SELECT_PIN <= 1'b1;
    end
    repeat (3) @(posedge CLK);
    FIRST_SELECT_PIN <= 1'b0;
    SECOND_SELECT_PIN <= 1'b0;
    repeat (4) @(posedge CLK);
  endtask

  initial begin
    repeat (20000) @(posedge CLK);
    err_count++;
    tally_and_finish();
  end

  initial begin
    {RESET, PSEL, PENABLE, PWRITE, S_VALID, M_READY} = 6'h20;
    {FIRST_SELECT_PIN, SECOND_SELECT_PIN} = 2'h0;
    {PADDR, PWDATA, PSTRB, S_I, S_Q} = '0;
    do_reset();
    rdc(ADDR_PATH, 8'h00);
    rdc(ADDR_EXT_DECIM, 8'h00);
    rdc(ADDR_NCO_CTRL, 8'h00);
    check("ratio", DECIM_RATIO, 6'h04);
    check("stages", STAGE_ENABLES, 6'h03);
    wr(ADDR_PATH, 8'hff);
    rdc(ADDR_PATH, 8'h4f);
    check("gain", GAIN_ON, 1'b1);
    check("real", REAL_OUTPUT, 1'b1);
    wr(ADDR_EXT_DECIM, 8'hff);
    rdc(ADDR_EXT_DECIM, 8'hf0);
    apb(1'b1, ADDR_PATH, 8'h00, 4'h0);
    rdc(ADDR_PATH, 8'h4f);
    apb(1'b0, 12'h000, 8'h00, 4'h0);
    check("unmapped err", e, 1'b1);
    check("unmapped data", rd, 8'h00);
    apb(1'b1, 12'h004, 8'h5a, 4'h1);
    check("unmapped wr err", e, 1'b1);
    wr(ADDR_PATH, 8'h00);
    check("gain off", GAIN_ON, 1'b0);
    check("complex", REAL_OUTPUT, 1'b0);
    for (int c = 0; c < 2; c++) begin
      for (int i = 0; i < 11; i++) begin
        wr(ADDR_EXT_DECIM, {ec[i], 4'h0});
        wr(ADDR_PATH, {4'h0, c[0], (i < 7) ? i[2:0] : DSEL_EXT});
        check("ratio", DECIM_RATIO, c[0] ? rr[i] : {rr[i][4:0], 1'b0});
        check("stages", STAGE_ENABLES, sm[i]);
        check("real", REAL_OUTPUT, c[0]);
      end
    end
    wr(ADDR_EXT_DECIM, 8'h50);
    check("odd ext code", DECIM_RATIO, 6'h18);
    wr(ADDR_NCO_CTRL, 8'h05);
    check("reg channel", NCO_CHANNEL, 4'h5);
    check("map channel", MAP_CHANNEL, 4'h5);
    wr(ADDR_NCO_CTRL, 8'h19);
    for (int p = 0; p < 4; p++) begin
      @(posedge CLK);
      {SECOND_SELECT_PIN, FIRST_SELECT_PIN} <= p[1:0];
      repeat (4) @(posedge CLK);
      check("pin channel", NCO_CHANNEL, {2'b00, p[1:0]});
    end
    check("map channel", MAP_CHANNEL, 4'h9);
    @(posedge CLK);
    {SECOND_SELECT_PIN, FIRST_SELECT_PIN} <= 2'h0;
    wr(ADDR_NCO_CTRL, 8'h82);
    check("edge start", NCO_CHANNEL, 4'h0);
    for (int k = 1; k < 4; k++) begin
      pulse(1'b0);
      check("edge count", NCO_CHANNEL, 4'(k % 3));
    end
    pulse(1'b1);
    check("other pin", NCO_CHANNEL, 4'h0);
    pulse(1'b0);
    pulse(1'b0);
    rdc(ADDR_STATUS, 8'h22);
    pulse(1'b0);
    wr(ADDR_NCO_CTRL, 8'ha1);
    pulse(1'b0);
    check("other pin", NCO_CHANNEL, 4'h0);
    pulse(1'b1);
    check("edge two", NCO_CHANNEL, 4'h1);
    pulse(1'b1);
    check("edge wrap", NCO_CHANNEL, 4'h0);
    do_reset();
    wr(ADDR_PATH, 8'h0b);
    push(16'h0100, 16'h0011);
    push(16'h0200, 16'h0022);
    push(16'h0300, 16'h0033);
    push(16'h0400, 16'h0044);
    repeat (2) @(negedge CLK);
    check("full", S_READY, 1'b0);
    pop(16'h0100, 16'h0000);
    pop(16'hffde, 16'h0000);
    pop(16'hfd00, 16'h0000);
    pop(16'h0044, 16'h0000);
    repeat (2) @(negedge CLK);
    check("empty", M_VALID, 1'b0);
    do_reset();
    wr(ADDR_PATH, 8'h43);
    push(16'h5000, 16'h0123);
    push(16'h1111, 16'h2222);
    push(16'hf000, 16'h0010);
    push(16'h3333, 16'h4444);
    pop(16'h7fff, 16'h0246);
    pop(16'he000, 16'h0020);
    repeat (2) @(negedge CLK);
    check("decimated", M_VALID, 1'b0);
    do_reset();
    wr(ADDR_PATH, 8'h03);
    push(16'h1234, 16'h8765);
    push(16'h0001, 16'h0002);
    pop(16'h1234, 16'h8765);
    tally_and_finish();
  end
endmodule
